// ### shared/pcu_defines.svh
// Constants for the PWM channel value update block.
// Assumes inclusion by the channel design file by bare name.
`ifndef PCU_DEFINES_SVH
`define PCU_DEFINES_SVH

// ****************************************
// Values
// ****************************************
`define PCU_FREE_TOP 16'hFFFF
`define PCU_ZERO16 16'h0000
`define PCU_ONE16 16'h0001
`define PCU_CLK_OFF 2'h0
`define PCU_MOD_RST 16'h0000
`define PCU_CV_RST 16'h0000

`endif

// ### shared/pcu_pkg.sv
// Types for the PWM channel value update block.
// Assumes the defines header is compiled alongside.
package pcu_pkg;

    // ****************************************
    // Byte write strobes from the CPU side
    // ****************************************
    typedef struct packed {
        logic cv_hi_we;
        logic cv_lo_we;
        logic mod_hi_we;
        logic mod_lo_we;
        logic sc_we;
        logic [7:0] data;
    } pcu_wr_t;

    // Counting direction
    typedef enum logic {
        PCU_UP = 1'b0,
        PCU_DOWN = 1'b1
    } pcu_dir_t;

endpackage

// ### verilog/pcu_coherent_write.sv
// Two-byte coherent write buffer for a 16-bit value.
// Assumes byte strobes and data come from logic on the same clock.
module pcu_coherent_write #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [W/2-1:0] data,
    input wire logic clear,
    input wire logic take,
    output logic [W-1:0] value,
    output logic full,
    output logic pending
);

    logic hi_q;
    logic lo_q;
    logic hi_d;
    logic lo_d;

    // ****************************************
    // Byte flags; a new byte beats take or clear
    // ****************************************
    assign hi_d = wr_hi | (hi_q & ~take & ~clear);
    assign lo_d = wr_lo | (lo_q & ~take & ~clear);
    assign full = hi_q & lo_q;
    assign pending = hi_q | lo_q;

    // Flag and byte storage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            value <= '0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
            if (wr_hi) begin
                value[W-1:W/2] <= data;
            end
            if (wr_lo) begin
                value[W/2-1:0] <= data;
            end
        end
    end

endmodule

// ### verilog/pcu_channel.sv
// One PWM channel with its counter, buffered channel value and modulus.
// Assumes count_step is a one-cycle prescaler pulse on the same clock and
// that the CPU write strobes and debug flag are synchronous to clock.
`include "pcu_defines.svh"
module pcu_channel #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire pcu_pkg::pcu_wr_t wr,
    input wire logic [1:0] clock_source_select,
    input wire logic center_mode,
    input wire logic background_debug_mode,
    input wire logic count_step,
    output logic pwm_out,
    output logic [W-1:0] counter,
    output logic [W-1:0] channel_value,
    output logic [W-1:0] counter_modulus,
    output logic cv_pending
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] cv_act_q;
    logic [W-1:0] cv_used_q;
    logic [W-1:0] cv_used_d;
    logic [W-1:0] mod_q;
    logic [W-1:0] cv_buf;
    logic [W-1:0] mod_buf;
    logic [W-1:0] top;
    logic [W-1:0] up_nx;
    logic [W-1:0] dn_nx;
    pcu_pkg::pcu_dir_t dir_q;
    pcu_pkg::pcu_dir_t dir_d;
    logic pwm_q;
    logic pwm_d;
    logic cv_full;
    logic mod_full;
    logic mod_pend;
    logic clk_on;
    logic step;
    logic at_load;
    logic xfer;
    logic period_start;
    logic zero_swap;
    logic up_hit;
    logic dn_hit;
    logic cv_zero;
    logic full_duty;

    // ****************************************
    // Byte buffers
    // ****************************************
    pcu_coherent_write #(.W(W)) u_cv_buf (
        .clock(clock),
        .arst_n(arst_n),
        .wr_hi(wr.cv_hi_we),
        .wr_lo(wr.cv_lo_we),
        .data(wr.data),
        .clear(1'b0),
        .take(xfer),
        .value(cv_buf),
        .full(cv_full),
        .pending(cv_pending)
    );

    // Debug status write drops a half-written modulus
    pcu_coherent_write #(.W(W)) u_mod_buf (
        .clock(clock),
        .arst_n(arst_n),
        .wr_hi(wr.mod_hi_we),
        .wr_lo(wr.mod_lo_we),
        .data(wr.data),
        .clear(background_debug_mode & wr.sc_we),
        .take(mod_full),
        .value(mod_buf),
        .full(mod_full),
        .pending(mod_pend)
    );

    // ****************************************
    // Counter range and stepping
    // ****************************************
    assign clk_on = clock_source_select != `PCU_CLK_OFF;
    assign step = count_step & clk_on & ~background_debug_mode;
    // Zero or all-ones modulus means free running
    assign top = (mod_q == `PCU_MOD_RST || mod_q == `PCU_FREE_TOP) ? `PCU_FREE_TOP : mod_q;
    assign up_nx = cnt_q + `PCU_ONE16;
    assign dn_nx = cnt_q - `PCU_ONE16;

    // Up to top, then down to zero in center mode
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (step) begin
            if (!center_mode) begin
                cnt_d = (cnt_q >= top) ? `PCU_ZERO16 : up_nx;
                dir_d = pcu_pkg::PCU_UP;
            end else begin
                cnt_d = (dir_q == pcu_pkg::PCU_UP && cnt_q < top) || cnt_q == `PCU_ZERO16 ? up_nx : dn_nx;
                case (dir_q)
                    pcu_pkg::PCU_UP: dir_d = (cnt_d >= top) ? pcu_pkg::PCU_DOWN : pcu_pkg::PCU_UP;
                    pcu_pkg::PCU_DOWN: dir_d = (cnt_d == `PCU_ZERO16) ? pcu_pkg::PCU_UP : pcu_pkg::PCU_DOWN;
                    default: dir_d = pcu_pkg::PCU_UP;
                endcase
            end
        end
    end

    // ****************************************
    // Channel value transfer
    // ****************************************
    // Load point: upward step from top minus one to top
    assign at_load = step & (dir_q == pcu_pkg::PCU_UP) & (cnt_q == top - `PCU_ONE16);
    // Without a clock source a full write lands at once
    assign xfer = cv_full & (clk_on ? at_load : 1'b1);
    assign period_start = step & (cnt_d == `PCU_ZERO16) & (cnt_q != `PCU_ZERO16);
    // In center mode a swap to or from zero waits for the period boundary
    assign zero_swap = center_mode & ((cv_act_q == `PCU_ZERO16) != (cv_used_q == `PCU_ZERO16));
    assign cv_used_d = (~zero_swap | period_start) ? cv_act_q : cv_used_q;

    // ****************************************
    // Output decode
    // ****************************************
    assign cv_zero = cv_used_q == `PCU_ZERO16;
    assign full_duty = cv_used_q >= top;
    assign up_hit = step & (dir_q == pcu_pkg::PCU_UP) & (cnt_d == cv_used_q) & (cnt_d > cnt_q);
    assign dn_hit = step & (dir_q == pcu_pkg::PCU_DOWN) & (cnt_d == cv_used_q) & (cnt_d < cnt_q);

    // Edge mode compares; center mode acts on matches
    always_comb begin
        pwm_d = pwm_q;
        if (!center_mode) begin
            pwm_d = cnt_q < cv_used_q;
        end else if (cv_zero) begin
            pwm_d = 1'b0;
        end else if (full_duty) begin
            pwm_d = 1'b1;
        end else if (dn_hit) begin
            pwm_d = 1'b1;
        end else if (up_hit) begin
            pwm_d = 1'b0;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= `PCU_ZERO16;
            dir_q <= pcu_pkg::PCU_UP;
            cv_act_q <= `PCU_CV_RST;
            cv_used_q <= `PCU_CV_RST;
            mod_q <= `PCU_MOD_RST;
            pwm_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            cv_used_q <= cv_used_d;
            pwm_q <= pwm_d;
            if (xfer) begin
                cv_act_q <= cv_buf;
            end
            if (mod_full) begin
                mod_q <= mod_buf;
            end
        end
    end

    assign pwm_out = pwm_q;
    assign counter = cnt_q;
    assign channel_value = cv_act_q;
    assign counter_modulus = mod_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_edge_load: assert property (
        !center_mode && clk_on && cv_full && at_load |=> cv_act_q == $past(cv_buf))
        else $error("edge mode value not loaded at top");
    a_load_only_top: assert property (
        clk_on && !$past(at_load) && $past(clk_on) |-> $stable(cv_act_q))
        else $error("channel value changed away from load point");
    a_center_load: assert property (
        center_mode && clk_on && cv_full && at_load |=> cv_act_q == $past(cv_buf))
        else $error("center mode value not loaded at top");
    a_free_load: assert property (
        clk_on && cv_full && step && top == `PCU_FREE_TOP && cnt_q == 16'hFFFE
        && dir_q == pcu_pkg::PCU_UP |=> cv_act_q == $past(cv_buf))
        else $error("free running value not loaded at FFFE");
    a_full_duty: assert property (
        center_mode && cv_used_q == top && cv_used_q != `PCU_ZERO16 |=> pwm_q)
        else $error("full duty output not active");
    a_near_full: assert property (
        center_mode && cv_used_q == top - `PCU_ONE16 && !cv_zero && dn_hit |=> pwm_q ##1 pwm_q)
        else $error("near full duty output not active");
    a_zero_hold: assert property (
        center_mode && cv_zero && cv_act_q != `PCU_ZERO16 && !period_start |=> cv_used_q == `PCU_ZERO16)
        else $error("zero duty left before period start");
    a_finish_old: assert property (
        center_mode && !cv_zero && cv_act_q == `PCU_ZERO16 && !period_start
        |=> cv_used_q == $past(cv_used_q))
        else $error("old duty not kept to period end");
    a_debug_clear: assert property (
        background_debug_mode && wr.sc_we && !wr.mod_hi_we && !wr.mod_lo_we |=> !mod_pend)
        else $error("debug status write kept modulus half write");
    a_up_match: assert property (
        center_mode && up_hit && !cv_zero && !full_duty |=> !pwm_q)
        else $error("up count match did not deactivate output");

endmodule

// ### tb/pcu_channel_tb_top.sv
// Self-checking bench for the PWM channel value update block.
// Assumes the package and the design files are compiled before it.
module pcu_channel_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and counters
    // ****************************************
    localparam logic [4:0] CVH = 5'h10;
    localparam logic [4:0] CVL = 5'h08;
    localparam logic [4:0] MH = 5'h04;
    localparam logic [4:0] ML = 5'h02;
    localparam logic [4:0] SC = 5'h01;
    logic clock;
    logic arst_n;
    pcu_pkg::pcu_wr_t wr;
    logic [1:0] clock_source_select;
    logic center_mode;
    logic background_debug_mode;
    logic count_step;
    logic pwm_out;
    logic cv_pending;
    logic [15:0] counter;
    logic [15:0] channel_value;
    logic [15:0] counter_modulus;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;

    pcu_channel u_pcu_channel (
        .clock(clock),
        .arst_n(arst_n),
        .wr(wr),
        .clock_source_select(clock_source_select),
        .center_mode(center_mode),
        .background_debug_mode(background_debug_mode),
        .count_step(count_step),
        .pwm_out(pwm_out),
        .counter(counter),
        .channel_value(channel_value),
        .counter_modulus(counter_modulus),
        .cv_pending(cv_pending)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Hang guard, about 70k cycles expected
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One byte strobe for one cycle
    task automatic wbyte(input logic [4:0] s, input logic [7:0] d);
        @(negedge clock);
        wr = {s, d};
        @(negedge clock);
        wr = '0;
    endtask

    // Count steps held for n cycles
    task automatic step(input int n);
        @(negedge clock);
        count_step = 1'b1;
        repeat (n) @(negedge clock);
        count_step = 1'b0;
    endtask

    // Reset, modulus and channel value loaded while stopped, then clock on
    task automatic setup(input logic c, input logic [15:0] m, input logic [15:0] v);
        @(negedge clock);
        arst_n = 1'b0;
        clock_source_select = 2'h0;
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        center_mode = c;
        wbyte(MH, m[15:8]);
        wbyte(ML, m[7:0]);
        wbyte(CVH, v[15:8]);
        wbyte(CVL, v[7:0]);
        repeat (3) @(negedge clock);
        clock_source_select = 2'h1;
    endtask

    // Single steps, output judged one cycle after each
    task automatic center_seq(input string pat, input string what);
        for (int i = 0; i < pat.len(); i++) begin
            step(1);
            @(negedge clock);
            if (pat[i] != "-")
                chk(what, pwm_out, pat[i] == "1");
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_edge();
        setup(1'b0, 16'h0004, 16'h0000);
        wbyte(CVL, 8'h02);
        step(4);
        chk("counter", counter, 16'h0004);
        chk("lone byte value", channel_value, 16'h0000);
        chk("lone byte pending", cv_pending, 16'h0001);
        step(1);
        wbyte(CVH, 8'h00);
        step(3);
        chk("value before top", channel_value, 16'h0000);
        step(1);
        chk("value at top", channel_value, 16'h0002);
        chk("pending cleared", cv_pending, 16'h0000);
        // Edge output high while the counter sits below the new value
        center_seq("11000", "edge duty");
        $display("test edge done");
    endtask

    task automatic test_free();
        setup(1'b0, 16'hFFFF, 16'h0000);
        wbyte(CVH, 8'h12);
        wbyte(CVL, 8'h34);
        step(65534);
        chk("free counter", counter, 16'hFFFE);
        chk("free value early", channel_value, 16'h0000);
        step(1);
        chk("free value", channel_value, 16'h1234);
        $display("test free done");
    endtask

    task automatic test_debug();
        setup(1'b0, 16'h0004, 16'h0000);
        background_debug_mode = 1'b1;
        wbyte(MH, 8'h12);
        wbyte(SC, 8'h00);
        wbyte(ML, 8'h34);
        repeat (3) @(negedge clock);
        chk("dropped modulus", counter_modulus, 16'h0004);
        wbyte(MH, 8'h56);
        repeat (3) @(negedge clock);
        chk("rebuilt modulus", counter_modulus, 16'h5634);
        background_debug_mode = 1'b0;
        wbyte(MH, 8'h00);
        wbyte(SC, 8'h00);
        wbyte(ML, 8'h07);
        repeat (3) @(negedge clock);
        chk("kept modulus", counter_modulus, 16'h0007);
        $display("test debug done");
    endtask

    task automatic test_center();
        setup(1'b1, 16'h0004, 16'h0004);
        center_seq("--------11111111", "full duty");
        setup(1'b1, 16'h0004, 16'h0003);
        center_seq("--------00001111110", "near full duty");
        setup(1'b1, 16'h0004, 16'h0002);
        center_seq("000000000000011110", "zero to nonzero");
        wbyte(CVH, 8'h00);
        wbyte(CVL, 8'h00);
        // Old duty still activates on the down match, zero from the next period
        center_seq("000110000", "nonzero to zero");
        chk("zero value", channel_value, 16'h0000);
        $display("test center done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        wr = '0;
        clock_source_select = 2'h0;
        center_mode = 1'b0;
        background_debug_mode = 1'b0;
        count_step = 1'b0;
        test_edge();
        test_debug();
        test_center();
        test_free();
        tally_and_finish();
    end
endmodule
